// *** src/fault_sup_pkg.sv ***
// Package: constants for the converter fault supervisor
package fault_sup_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] COMMAND_OFS     = 8'h00;
  localparam logic [7:0] CONFIG_OFS      = 8'h04;
  localparam logic [7:0] ILIM_OFS        = 8'h08;
  localparam logic [7:0] CABLE_COMP_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS      = 8'h10;
  localparam logic [7:0] MASK_OFS        = 8'h14;
  localparam logic [7:0] REGISTER_A_OFS  = 8'h18;
  localparam logic [7:0] PROT_STATUS_OFS = 8'h1C;
  // ==========================================================================
  // Commands
  localparam logic [7:0] CMD_SOURCE_DEFAULT = 8'h77;
  localparam logic [7:0] CMD_DISABLE_SOURCE = 8'h66;
  // ==========================================================================
  // Status / mask bit positions
  localparam int SRC_OC_BIT   = 0;
  localparam int VENDOR_BIT   = 1;
  localparam int OC_TIMED_BIT = 2;
  localparam int OCP_BIT      = 3;
  localparam int GND_BIT      = 4;
  localparam int THERM_BIT    = 5;
  localparam int EVENT_COUNT  = 6;
  // Config bit positions
  localparam int LIM_EN_BIT   = 0;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] ILIM_RESET  = 8'hFF;
  localparam logic [5:0] GAIN_RESET  = 6'h00;
  localparam logic [5:0] MASK_RESET  = 6'h3F;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int DEBOUNCE_MS     = 16;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  // ==========================================================================
  // Converter state
  typedef enum logic [1:0] {
    CONV_OFF   = 2'b00,
    CONV_ON    = 2'b01,
    CONV_FAULT = 2'b11,
    CONV_HOT   = 2'b10
  } conv_state_type;
endpackage

// *** src/fault_supervisor.sv ***
// Converter fault supervisor with AXI4-Lite register slave
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int DEBOUNCE = DEBOUNCE_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_src_oc_cmp,
  input  wire logic        i_out_over_limit_cmp,
  input  wire logic        i_out_ocp_cmp,
  input  wire logic        i_gnd_high_cmp,
  input  wire logic        i_gnd_low_cmp,
  input  wire logic        i_therm_hot_cmp,
  input  wire logic        i_therm_cool_cmp,
  input  wire logic        i_high_voltage_enable_input,
  input  wire logic        i_input_undervoltage_lockout,
  output logic             o_conv_en,
  output logic             o_cc_mode_en,
  output logic             o_pulldown_en,
  output logic [5:0]       o_cable_gain,
  output logic [7:0]       o_current_limit,
  output logic             o_alert_n,
  output logic             o_irq
);
  // ==========================================================================
  // Pin synchronisers
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw = {i_src_oc_cmp, i_out_over_limit_cmp, i_out_ocp_cmp, i_gnd_high_cmp,
                i_gnd_low_cmp, i_therm_hot_cmp, i_therm_cool_cmp,
                i_high_voltage_enable_input, i_input_undervoltage_lockout};
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic src_oc, over_lim, ocp, gnd_hi, gnd_lo, hot, cool, hv_on, lockout;
  assign {src_oc, over_lim, ocp, gnd_hi, gnd_lo, hot, cool, hv_on, lockout} = s2_q;

  // ==========================================================================
  // Register state
  logic       lim_en_q, lim_en_d;
  logic [7:0] ilim_q, ilim_d;
  logic [5:0] gain_q, gain_d;
  logic [5:0] mask_q, mask_d;
  logic [5:0] stat_q, stat_d;
  logic       mode_flag_q, mode_flag_d;
  logic       start_cmd, stop_cmd;
  logic [5:0] ev;
  logic [5:0] w1c;

  // ==========================================================================
  // AXI4-Lite write channel, address and data taken in either order
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        do_write;
  logic        wr_hit;
  assign o_awready = !aw_hold_q && !bvalid_q;
  assign o_wready  = !w_hold_q && !bvalid_q;
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    do_write  = 1'b0;
    if (i_awvalid && o_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d  = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_hold_d = 1'b1;
      wdata_d  = i_wdata;
      wstrb_d  = i_wstrb;
    end
    if (aw_hold_q && w_hold_q) begin
      do_write  = 1'b1;
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? 2'b00 : 2'b10;
    end else if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
  end
  always_comb begin
    case (awaddr_q & 8'hFC)
      COMMAND_OFS, CONFIG_OFS, ILIM_OFS, CABLE_COMP_OFS, STATUS_OFS, MASK_OFS,
      REGISTER_A_OFS, PROT_STATUS_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end
  assign o_bvalid = bvalid_q;
  assign o_bresp  = bresp_q;

  // Register writes; only byte lane 0 carries fields
  logic wr_lane0;
  assign wr_lane0  = do_write && wstrb_q[0];
  assign start_cmd = wr_lane0 && (awaddr_q == COMMAND_OFS) && (wdata_q[7:0] == CMD_SOURCE_DEFAULT);
  assign stop_cmd  = wr_lane0 && (awaddr_q == COMMAND_OFS) && (wdata_q[7:0] == CMD_DISABLE_SOURCE);
  assign w1c       = (wr_lane0 && awaddr_q == STATUS_OFS) ? wdata_q[5:0] : 6'h00;

  // ==========================================================================
  // Converter state machine
  conv_state_type state_q, state_d;
  logic sourcing;
  logic src_oc_done, timed_oc_done;
  logic gnd_fault, ocp_fault, timed_fault;
  assign sourcing = (state_q == CONV_ON);
  assign gnd_fault = sourcing && (lim_en_q ? gnd_hi : gnd_lo);
  assign ocp_fault = sourcing && ocp;
  assign timed_fault = sourcing && timed_oc_done;
  always_comb begin
    state_d = state_q;
    case (state_q)
      CONV_OFF: begin
        if (start_cmd && !hot) begin
          state_d = CONV_ON;
        end
      end
      CONV_ON: begin
        if (stop_cmd) begin
          state_d = CONV_OFF;
        end else if (hot) begin
          state_d = CONV_HOT;
        end else if (ocp_fault || gnd_fault || timed_fault) begin
          state_d = CONV_FAULT;
        end
      end
      CONV_FAULT: begin
        if (start_cmd && !hot) begin
          state_d = CONV_ON;
        end else if (stop_cmd) begin
          state_d = CONV_OFF;
        end
      end
      CONV_HOT: begin
        if (stop_cmd) begin
          state_d = CONV_OFF;
        end else if (cool && hv_on && !lockout) begin
          state_d = CONV_ON;
        end
      end
      default: state_d = CONV_OFF;
    endcase
  end

  // ==========================================================================
  // Debounce timers
  // input OC debounce
  oc_debounce #(.CYCLES(DEBOUNCE)) u_src_oc (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_level (src_oc),
    .o_done  (src_oc_done)
  );
  oc_debounce #(.CYCLES(DEBOUNCE)) u_out_oc (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_level (sourcing && !lim_en_q && over_lim),
    .o_done  (timed_oc_done)
  );

  // ==========================================================================
  // Status, mask and config registers; set wins over clear
  logic cc_mode;
  assign ev[SRC_OC_BIT]   = src_oc_done;
  // vendor alert from unmasked input OC
  assign ev[VENDOR_BIT]   = stat_q[SRC_OC_BIT] && mask_q[SRC_OC_BIT];
  assign ev[OC_TIMED_BIT] = timed_fault;
  assign ev[OCP_BIT]      = ocp_fault;
  assign ev[GND_BIT]      = gnd_fault;
  assign ev[THERM_BIT]    = sourcing && hot;
  // CC only with enable and over threshold
  assign cc_mode = sourcing && lim_en_q && over_lim;
  always_comb begin
    lim_en_d = lim_en_q;
    ilim_d  = ilim_q;
    gain_d  = gain_q;
    mask_d  = mask_q;
    stat_d  = (stat_q & ~w1c) | ev;
    mode_flag_d = mode_flag_q | (cc_mode != o_cc_mode_en);
    if (wr_lane0 && awaddr_q == REGISTER_A_OFS && wdata_q[0]) begin
      mode_flag_d = (cc_mode != o_cc_mode_en);
    end
    if (wr_lane0) begin
      case (awaddr_q)
        CONFIG_OFS:     lim_en_d = wdata_q[LIM_EN_BIT];
        ILIM_OFS:       ilim_d  = wdata_q[7:0];
        CABLE_COMP_OFS: gain_d  = wdata_q[5:0];
        MASK_OFS:       mask_d  = wdata_q[5:0];
        default:        ;
      endcase
    end
  end
  logic cc_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= CONV_OFF;
      lim_en_q    <= 1'b0;
      ilim_q      <= ILIM_RESET;
      gain_q      <= GAIN_RESET;
      mask_q      <= MASK_RESET;
      stat_q      <= 6'h00;
      mode_flag_q <= 1'b0;
      cc_q        <= 1'b0;
    end else begin
      state_q     <= state_d;
      lim_en_q    <= lim_en_d;
      ilim_q      <= ilim_d;
      gain_q      <= gain_d;
      mask_q      <= mask_d;
      stat_q      <= stat_d;
      mode_flag_q <= mode_flag_d;
      cc_q        <= cc_mode;
    end
  end

  // ==========================================================================
  // Read channel, one cycle after acceptance
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  assign o_arready = !rvalid_q;
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (i_arvalid && o_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = 2'b00;
      case (i_araddr & 8'hFC)
        COMMAND_OFS:     rdata_d = 32'h0000_0000;
        CONFIG_OFS:      rdata_d = {31'h0000_0000, lim_en_q};
        ILIM_OFS:        rdata_d = {24'h00_0000, ilim_q};
        CABLE_COMP_OFS:  rdata_d = {26'h000_0000, gain_q};
        STATUS_OFS:      rdata_d = {26'h000_0000, stat_q};
        MASK_OFS:        rdata_d = {26'h000_0000, mask_q};
        REGISTER_A_OFS:  rdata_d = {31'h0000_0000, mode_flag_q};
        PROT_STATUS_OFS: rdata_d = {28'h000_0000, state_q, o_pulldown_en, cc_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = 2'b10;
        end
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'b00;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end
  assign o_rvalid = rvalid_q;
  assign o_rdata  = rdata_q;
  assign o_rresp  = rresp_q;

  // ==========================================================================
  // Outputs
  assign o_conv_en       = sourcing;
  assign o_pulldown_en   = !sourcing;
  assign o_cc_mode_en    = cc_q;
  assign o_cable_gain    = gain_q;
  assign o_current_limit = ilim_q;
  assign o_alert_n       = !(stat_q[VENDOR_BIT] && mask_q[VENDOR_BIT]);
  // Level interrupt from any unmasked sticky bit
  assign o_irq           = |(stat_q & mask_q);

  // ==========================================================================
  // Assertions
  cl_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !lim_en_q |=> !o_cc_mode_en)
    else $error("cc mode entered while limit disabled");
  cc_enter_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sourcing && lim_en_q && over_lim) |=> o_cc_mode_en)
    else $error("cc mode not entered above threshold");
  ocp_trip_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sourcing && ocp && !stop_cmd && !hot) |=> !o_conv_en ##0 stat_q[OCP_BIT])
    else $error("fixed overcurrent did not turn off");
  gnd_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sourcing && lim_en_q && gnd_hi && !stop_cmd && !hot) |=> state_q == CONV_FAULT)
    else $error("short to ground not acted on");
  pulldown_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_pulldown_en == !o_conv_en)
    else $error("pulldown state wrong");
  alert_pin_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (stat_q[VENDOR_BIT] && mask_q[VENDOR_BIT]) |-> !o_alert_n)
    else $error("alert pin not low");
  vendor_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (stat_q[SRC_OC_BIT] && mask_q[SRC_OC_BIT]) |=> stat_q[VENDOR_BIT])
    else $error("vendor alert not set");
  fault_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == CONV_FAULT && !start_cmd) |=> !o_conv_en)
    else $error("converter restarted without command");
  src_oc_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(stat_q[SRC_OC_BIT]) |-> $past(src_oc, 2))
    else $error("input overcurrent flag set without overcurrent");
endmodule

// *** src/oc_debounce.sv ***
// Continuous-level debounce timer
`timescale 1ns/1ps
module oc_debounce
  import fault_sup_pkg::*;
#(
  parameter int CYCLES = DEBOUNCE_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_level,
  output logic      o_done
);
  localparam int W = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("CYCLES must be at least 1");
  end
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         done_q;
  logic         done_d;
  // ==========================================================================
  // Counter restarts on any drop of the level
  always_comb begin
    count_d = count_q;
    done_d  = 1'b0;
    if (!i_level) begin
      count_d = '0;
    end else if (count_q == W'(CYCLES)) begin
      done_d = 1'b1;
    end else begin
      count_d = count_q + W'(1);
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= '0;
      done_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      done_q  <= done_d;
    end
  end
  assign o_done = done_q;
endmodule

// *** test/axi_host_model.sv ***
// Host-side AXI4-Lite master model that drives the supervisor registers
`timescale 1ns/1ps
module axi_host_model
  import fault_sup_pkg::*;
(
  input  wire logic        i_clk,
  output logic [7:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic [7:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready,
  output logic             o_hang
);
  // ==========================================================================
  // Bus cycles
  initial begin
    {o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_hang} = '0;
  end
  // Released address and data lines show the inverse so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge i_clk);
    o_awaddr  <= a;
    o_awvalid <= 1'b1;
    o_wdata   <= d;
    o_wstrb   <= 4'hF;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
    end while (!(o_bready && i_bvalid) && n < 200);
    resp = i_bresp;
    o_bready <= 1'b0;
    if (n >= 200) o_hang <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge i_clk);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr  <= ~a;
      end
    end while (!(o_rready && i_rvalid) && n < 200);
    d    = i_rdata;
    resp = i_rresp;
    o_rready <= 1'b0;
    if (n >= 200) o_hang <= 1'b1;
  endtask
  // ==========================================================================
  // Sourcing commands
  // limit mode, then start
  task automatic start(input logic cl);
    logic [1:0] r;
    wr(CONFIG_OFS, {31'h0, cl}, r);
    wr(COMMAND_OFS, {24'h0, CMD_SOURCE_DEFAULT}, r);
  endtask
  task automatic stop();
    logic [1:0] r;
    wr(COMMAND_OFS, {24'h0, CMD_DISABLE_SOURCE}, r);
  endtask
endmodule

// *** test/tb_converter_fault_supervisor.sv ***
// Self-checking bench for the converter fault supervisor
`timescale 1ns/1ps
module tb_converter_fault_supervisor
  import fault_sup_pkg::*;
;
  // ==========================================================================
  // Signals
  localparam int DB = 20;
  logic        clk, rst_n, src_oc, over_lim, ocp, gnd_hi, gnd_lo, hot, cool, hv_on, lockout;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, hang;
  logic        arvalid, arready, rvalid, rready, conv_en, cc_en, pd_en, alert_n, irq;
  logic [7:0]  awaddr, araddr, lim;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [5:0]  gain;
  int          miscompares, cmp_count;
  // Short debounce keeps the run brief; expectations derive from DB
  fault_supervisor #(.DEBOUNCE(DB)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_src_oc_cmp(src_oc), .i_out_over_limit_cmp(over_lim), .i_out_ocp_cmp(ocp),
    .i_gnd_high_cmp(gnd_hi), .i_gnd_low_cmp(gnd_lo), .i_therm_hot_cmp(hot),
    .i_therm_cool_cmp(cool), .i_high_voltage_enable_input(hv_on),
    .i_input_undervoltage_lockout(lockout), .o_conv_en(conv_en), .o_cc_mode_en(cc_en),
    .o_pulldown_en(pd_en), .o_cable_gain(gain), .o_current_limit(lim), .o_alert_n(alert_n),
    .o_irq(irq)
  );
  axi_host_model host (
    .i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
    .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
    .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid),
    .o_rready(rready), .o_hang(hang)
  );
  always #12.5 clk = ~clk;
  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(a, d, r);
    chk("rresp", 32'h0, {30'h0, r});
    chk($sformatf("reg %0h", a), e, d & m);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // A stuck bus or a runaway run ends in the closing report
  always @(posedge hang) begin
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {clk, rst_n, src_oc, over_lim, ocp, gnd_hi, gnd_lo, hot, cool, lockout} = '0;
    hv_on = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    chk("pulldown", 32'h1, {31'h0, pd_en});
    chk("alert_n", 32'h1, {31'h0, alert_n});
    chk("limit", 32'hFF, {24'h0, lim});
    rd(MASK_OFS, 32'h3F, 32'h3F);
    rd(CONFIG_OFS, 32'h1, 32'h0);
    wr(CABLE_COMP_OFS, 32'h2A);
    chk("gain", 32'h2A, {26'h0, gain});
    rd(CABLE_COMP_OFS, 32'h3F, 32'h2A);
    wr(ILIM_OFS, 32'h5A);
    chk("limit", 32'h5A, {24'h0, lim});
    host.wr(8'h40, 32'h1, r);
    chk("bresp unmapped", 32'h2, {30'h0, r});
    host.rd(8'h40, d, r);
    chk("rresp unmapped", 32'h2, {30'h0, r});
    // Limit enabled: regulation mode, then higher short threshold
    host.start(1'b1);
    chk("conv_en", 32'h1, {31'h0, conv_en});
    chk("pulldown", 32'h0, {31'h0, pd_en});
    @(posedge clk) over_lim <= 1'b1;
    settle(6);
    chk("cc_mode", 32'h1, {31'h0, cc_en});
    rd(PROT_STATUS_OFS, 32'h1, 32'h1);
    rd(REGISTER_A_OFS, 32'h1, 32'h1);
    chk("gain in cc", 32'h2A, {26'h0, gain});
    @(posedge clk) over_lim <= 1'b0;
    settle(6);
    chk("cc_mode", 32'h0, {31'h0, cc_en});
    @(posedge clk) gnd_hi <= 1'b1;
    settle(6);
    chk("conv_en", 32'h0, {31'h0, conv_en});
    chk("pulldown", 32'h1, {31'h0, pd_en});
    @(posedge clk) gnd_hi <= 1'b0;
    settle(6);
    chk("conv_en", 32'h0, {31'h0, conv_en});
    rd(STATUS_OFS, 32'h10, 32'h10);
    // Limit disabled: lower short threshold only
    host.start(1'b0);
    @(posedge clk) gnd_hi <= 1'b1;
    settle(6);
    chk("conv_en", 32'h1, {31'h0, conv_en});
    @(posedge clk) gnd_lo <= 1'b1;
    settle(6);
    chk("conv_en", 32'h0, {31'h0, conv_en});
    @(posedge clk) {gnd_hi, gnd_lo} <= 2'h0;
    // Timed overcurrent turn-off, no constant current
    host.start(1'b0);
    @(posedge clk) over_lim <= 1'b1;
    settle(DB - 6);
    chk("conv_en", 32'h1, {31'h0, conv_en});
    chk("cc_mode", 32'h0, {31'h0, cc_en});
    settle(20);
    chk("conv_en", 32'h0, {31'h0, conv_en});
    @(posedge clk) over_lim <= 1'b0;
    rd(STATUS_OFS, 32'h4, 32'h4);
    // Fixed overcurrent level
    host.start(1'b0);
    @(posedge clk) ocp <= 1'b1;
    settle(6);
    chk("conv_en", 32'h0, {31'h0, conv_en});
    @(posedge clk) ocp <= 1'b0;
    rd(STATUS_OFS, 32'h8, 32'h8);
    // Thermal shutdown and conditional restart
    host.start(1'b1);
    @(posedge clk) hot <= 1'b1;
    settle(6);
    chk("conv_en", 32'h0, {31'h0, conv_en});
    @(posedge clk) {hot, cool, hv_on, lockout} <= 4'h4;
    settle(6);
    chk("conv_en", 32'h0, {31'h0, conv_en});
    @(posedge clk) {hv_on, lockout} <= 2'h3;
    settle(6);
    chk("conv_en", 32'h0, {31'h0, conv_en});
    @(posedge clk) lockout <= 1'b0;
    settle(6);
    chk("conv_en", 32'h1, {31'h0, conv_en});
    rd(STATUS_OFS, 32'h20, 32'h20);
    @(posedge clk) cool <= 1'b0;
    host.stop();
    settle(4);
    chk("pulldown", 32'h1, {31'h0, pd_en});
    wr(STATUS_OFS, 32'h3F);
    chk("irq", 32'h0, {31'h0, irq});
    // Input overcurrent debounce, alert path and masks
    @(posedge clk) src_oc <= 1'b1;
    repeat (5) @(posedge clk);
    src_oc <= 1'b0;
    settle(10);
    rd(STATUS_OFS, 32'h1, 32'h0);
    @(posedge clk) src_oc <= 1'b1;
    settle(DB - 4);
    rd(STATUS_OFS, 32'h1, 32'h0);
    settle(20);
    rd(STATUS_OFS, 32'h3, 32'h3);
    chk("alert_n", 32'h0, {31'h0, alert_n});
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge clk) src_oc <= 1'b0;
    wr(MASK_OFS, 32'h3D);
    chk("alert_n", 32'h1, {31'h0, alert_n});
    wr(STATUS_OFS, 32'h3F);
    wr(STATUS_OFS, 32'h3F);
    wr(MASK_OFS, 32'h3E);
    @(posedge clk) src_oc <= 1'b1;
    settle(DB + 16);
    rd(STATUS_OFS, 32'h3, 32'h1);
    chk("alert_n", 32'h1, {31'h0, alert_n});
    tally_and_finish();
  end
endmodule
